// ### include/twm_pkg.sv
// Constants of the tick timer and watchdog block: register map, field
// positions, reset values and the power mode encoding.
// Assumes a 32-bit APB register bus with byte addresses.
package twm_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_PRESCALER = 8'h04;
  localparam logic [7:0] ADDR_PRESET = 8'h08;
  localparam logic [7:0] ADDR_CONTROL = 8'h0c;
  localparam logic [7:0] ADDR_WD_COUNT = 8'h10;
  localparam logic [7:0] ADDR_WD_MATCH = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // Configuration bits
  localparam int unsigned CFG_LOCK_CONFIG = 0;
  localparam int unsigned CFG_LOCK_PRESCALER = 1;
  localparam int unsigned CFG_LOCK_TIMER = 2;
  localparam int unsigned CFG_LOCK_COUNT = 3;
  localparam int unsigned CFG_WD_CLOCK_SELECT = 4;
  localparam int unsigned CFG_MATCH_ENABLE = 5;

  // Timer control and status bits
  localparam int unsigned CTL_RESTART = 0;
  localparam int unsigned CTL_TERMINAL = 1;
  localparam int unsigned CTL_IRQ_ENABLE = 2;

  // Status register: watchdog count in the low byte, running flag above
  localparam int unsigned STS_STARTED = 8;

  // Reset values
  localparam logic [5:0] CONFIG_RST = 6'h00;
  localparam logic [2:0] PRESCALER_RST = 3'h0;
  localparam logic [15:0] PRESET_RST = 16'hffff;
  localparam logic [7:0] WD_COUNT_RST = 8'h0f;

  // Key value that services the watchdog in match mode
  localparam logic [7:0] SERVICE_KEY = 8'h5c;
  // Highest legal prescaler code (divide by 32)
  localparam logic [2:0] PRESCALER_MAX = 3'h5;
  // Read answer of a locked or inaccessible register
  localparam logic [31:0] BLOCKED_READ = 32'hdead_beef;

  typedef enum logic [1:0] {
    MODE_ACTIVE,
    MODE_POWER_SAVE,
    MODE_IDLE,
    MODE_HALT
  } power_mode_t;

endpackage : twm_pkg

// ### include/twm_link_if.sv
// Signals between the register/timer core, the prescaler and the watchdog.
// All three sit on pclk; every signal here is a same-clock level or pulse.
`timescale 1ns/1ns
interface twm_link_if;
  logic freeze;
  logic [2:0] mdiv;
  logic prescaled_tick_clock_rise;
  logic wd_edge;
  logic match_en;
  logic cnt_wr;
  logic svc_wr;
  logic [7:0] wdata;
  logic started;
  logic [7:0] wd_cnt;
  logic wd_error;

  modport presc(input freeze, input mdiv, output prescaled_tick_clock_rise);
  modport wdog(input wd_edge, input match_en, input cnt_wr, input svc_wr, input wdata,
               output started, output wd_cnt, output wd_error);
  modport ctrl(output freeze, output mdiv, output wd_edge, output match_en, output cnt_wr,
               output svc_wr, output wdata, input prescaled_tick_clock_rise, input started, input wd_cnt,
               input wd_error);
endinterface : twm_link_if

// ### rtl/tick_prescaler.sv
// Slow clock synchroniser and divider; emits one pclk pulse per rising
// edge of the prescaled tick clock.
// Assumes slow_clock is far slower than pclk and unrelated to it.
`timescale 1ns/1ns
module tick_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow_clock,
  twm_link_if.presc lk
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [4:0] div;
    logic rise;
  } presc_state_t;

  presc_state_t st_reg, st_next;
  logic slow_edge;
  logic [4:0] mask;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = slow_clock;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // Reserved codes fall back to the slowest ratio
    mask = (lk.mdiv > twm_pkg::PRESCALER_MAX) ? 5'h1f : 5'((6'h01 << lk.mdiv) - 6'h01);
    slow_edge = st_reg.s2 & ~st_reg.s3 & ~lk.freeze;
    st_next.rise = slow_edge && ((st_reg.div & mask) == mask);
    if (slow_edge) begin
      st_next.div = st_reg.div + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign lk.prescaled_tick_clock_rise = st_reg.rise;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rise_from_edge;
    lk.prescaled_tick_clock_rise |-> $past(st_reg.s2 & ~st_reg.s3 & ~lk.freeze);
  endproperty
  a_rise_from_edge: assert property (p_rise_from_edge)
    else $error("prescaled tick without a slow clock edge");
endmodule : tick_prescaler

// ### rtl/watchdog_core.sv
// Eight-bit watchdog counter with count and key-match servicing.
// Assumes wd_edge and the write pulses are single pclk cycles.
`timescale 1ns/1ns
module watchdog_core (
  input wire logic pclk,
  input wire logic presetn,
  twm_link_if.wdog lk
);
  typedef struct packed {
    logic [7:0] count_reg;
    logic [7:0] cnt;
    logic started;
    logic seen;
    logic err;
  } wd_state_t;

  wd_state_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    if (st_reg.started && lk.wd_edge) begin
      st_next.seen = 1'b0;
      st_next.cnt = st_reg.cnt - 8'h01;
      if (st_reg.cnt <= 8'h01) begin
        st_next.err = 1'b1;
      end
    end
    if (lk.cnt_wr) begin
      st_next.count_reg = lk.wdata;
      st_next.started = 1'b1;
      if (!lk.match_en) begin
        st_next.cnt = lk.wdata;
      end
    end
    if (lk.svc_wr) begin
      st_next.started = 1'b1;
      // Disabled match mode: no service and no error
      if (lk.match_en) begin
        if (lk.wdata != twm_pkg::SERVICE_KEY) begin
          st_next.err = 1'b1;
        end else if (st_reg.seen && !lk.wd_edge) begin
          st_next.err = 1'b1;
        end else begin
          st_next.cnt = st_reg.count_reg;
          st_next.seen = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.count_reg <= twm_pkg::WD_COUNT_RST;
      st_reg.cnt <= twm_pkg::WD_COUNT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign lk.started = st_reg.started;
  assign lk.wd_cnt = st_reg.cnt;
  assign lk.wd_error = st_reg.err;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_late_error;
    st_reg.started && lk.wd_edge && st_reg.cnt == 8'h01 |=> st_reg.err;
  endproperty
  a_late_error: assert property (p_late_error)
    else $error("watchdog reached zero without error");

  property p_bad_key;
    lk.svc_wr && lk.match_en && lk.wdata != 8'h5c |=> st_reg.err;
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("wrong service key did not raise error");

  property p_idle_quiet;
    !st_reg.started |-> !st_reg.err && $stable(st_reg.cnt);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("stopped watchdog counted or erred");
endmodule : watchdog_core

// ### rtl/tick_timer_and_watchdog.sv
// Tick timer and watchdog: APB registers, 16-bit periodic timer,
// instances of the prescaler and of the watchdog counter.
// Assumes an APB master on pclk, a free slow_clock pin and a power mode
// input from the power manager on pclk.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ns
module tick_timer_and_watchdog (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slow_clock,
  input wire twm_pkg::power_mode_t power_mode,
  output logic timer_tick_output,
  output logic periodic_tick_irq,
  output logic watchdog_reset
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] cfg;
    logic [2:0] mdiv;
    logic [15:0] preset;
    logic [15:0] cnt;
    logic restart;
    logic tc;
    logic inte;
    logic tick;
    logic irq;
    logic wd_reset;
  } top_state_t;

  top_state_t st_reg, st_next;
  twm_link_if link ();

  logic access;
  logic fire;
  logic wr_fire;
  logic mapped;
  logic allowed;
  logic [31:0] rd_value;
  logic [15:0] cnt_after;
  logic zero_after;

  ////////////////////////////////////////////////////////////////////////
  // Register access decode

  function automatic logic is_mapped(input logic [7:0] a);
    return a == twm_pkg::ADDR_CONFIG || a == twm_pkg::ADDR_PRESCALER ||
           a == twm_pkg::ADDR_PRESET || a == twm_pkg::ADDR_CONTROL ||
           a == twm_pkg::ADDR_WD_COUNT || a == twm_pkg::ADDR_WD_MATCH ||
           a == twm_pkg::ADDR_STATUS;
  endfunction : is_mapped

  // Lock bits and power mode decide whether a register may be touched
  function automatic logic is_allowed(input logic [7:0] a, input logic [5:0] cfg,
                                      input twm_pkg::power_mode_t m);
    logic active;
    active = (m == twm_pkg::MODE_ACTIVE);
    unique case (a)
      twm_pkg::ADDR_WD_MATCH: return m != twm_pkg::MODE_HALT;
      twm_pkg::ADDR_CONFIG: return active && !cfg[twm_pkg::CFG_LOCK_CONFIG];
      twm_pkg::ADDR_PRESCALER: return active && !cfg[twm_pkg::CFG_LOCK_PRESCALER];
      twm_pkg::ADDR_PRESET: return active && !cfg[twm_pkg::CFG_LOCK_TIMER];
      twm_pkg::ADDR_CONTROL: return active && !cfg[twm_pkg::CFG_LOCK_TIMER];
      twm_pkg::ADDR_WD_COUNT: return active && !cfg[twm_pkg::CFG_LOCK_COUNT];
      default: return active;
    endcase
  endfunction : is_allowed

  always_comb begin
    access = psel && penable && !st_reg.pready;
    // Writes and read side effects land on the edge where pready is seen
    fire = psel && penable && st_reg.pready;
    mapped = is_mapped(paddr);
    allowed = mapped && is_allowed(paddr, st_reg.cfg, power_mode);
    wr_fire = fire && pwrite && allowed;
  end

  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (paddr)
      twm_pkg::ADDR_CONFIG: rd_value[5:0] = st_reg.cfg;
      twm_pkg::ADDR_PRESCALER: rd_value[2:0] = st_reg.mdiv;
      twm_pkg::ADDR_PRESET: rd_value[15:0] = st_reg.preset;
      twm_pkg::ADDR_CONTROL: begin
        rd_value[twm_pkg::CTL_RESTART] = st_reg.restart;
        rd_value[twm_pkg::CTL_TERMINAL] = st_reg.tc;
        rd_value[twm_pkg::CTL_IRQ_ENABLE] = st_reg.inte;
      end
      twm_pkg::ADDR_STATUS: begin
        rd_value[7:0] = link.wd_cnt;
        rd_value[twm_pkg::STS_STARTED] = link.started;
      end
      // Count and match registers are write-only
      default: rd_value = 32'h0000_0000;
    endcase
    if (!allowed) begin
      rd_value = twm_pkg::BLOCKED_READ;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timer next count

  always_comb begin
    cnt_after = st_reg.cnt;
    if (link.prescaled_tick_clock_rise) begin
      if (st_reg.restart || st_reg.cnt == 16'h0000) begin
        // Reload always takes the preset stored now
        cnt_after = st_reg.preset;
      end else begin
        cnt_after = st_reg.cnt - 16'h0001;
      end
    end
    zero_after = (cnt_after == 16'h0000);
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_next = st_reg;

    // APB answer: one wait state, then pready for one cycle
    st_next.pready = access;
    if (access) begin
      st_next.prdata = rd_value;
      st_next.pslverr = !mapped;
    end else if (fire) begin
      st_next.prdata = 32'h0000_0000;
      st_next.pslverr = 1'b0;
    end

    // Timer
    st_next.cnt = cnt_after;
    if (link.prescaled_tick_clock_rise) begin
      st_next.tick = zero_after;
      st_next.irq = zero_after && st_reg.inte;
      st_next.restart = 1'b0;
    end

    // Read clears only a terminal flag that the read actually returned
    if (fire && !pwrite && allowed && paddr == twm_pkg::ADDR_CONTROL &&
        st_reg.prdata[twm_pkg::CTL_TERMINAL]) begin
      st_next.tc = 1'b0;
    end
    if (link.prescaled_tick_clock_rise && zero_after) begin
      st_next.tc = 1'b1;
    end

    // Register writes
    if (wr_fire) begin
      unique case (paddr)
        twm_pkg::ADDR_CONFIG: begin
          st_next.cfg = st_reg.cfg | pwdata[5:0];
        end
        twm_pkg::ADDR_PRESCALER: begin
          st_next.mdiv = pwdata[2:0];
        end
        twm_pkg::ADDR_PRESET: begin
          st_next.preset = pwdata[15:0];
        end
        twm_pkg::ADDR_CONTROL: begin
          st_next.inte = pwdata[twm_pkg::CTL_IRQ_ENABLE];
          // Writing 0 has no effect; a set beats the self-clear
          if (pwdata[twm_pkg::CTL_RESTART]) begin
            st_next.restart = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Sticky until the device reset that it requests
    if (link.wd_error) begin
      st_next.wd_reset = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.cfg <= twm_pkg::CONFIG_RST;
      st_reg.mdiv <= twm_pkg::PRESCALER_RST;
      st_reg.preset <= twm_pkg::PRESET_RST;
      st_reg.cnt <= twm_pkg::PRESET_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Submodules

  assign link.freeze = (power_mode == twm_pkg::MODE_HALT);
  assign link.mdiv = st_reg.mdiv;
  // Timer tick rises exactly when the count enters zero
  assign link.wd_edge = link.prescaled_tick_clock_rise &&
                        (st_reg.cfg[twm_pkg::CFG_WD_CLOCK_SELECT] || zero_after);
  assign link.match_en = st_reg.cfg[twm_pkg::CFG_MATCH_ENABLE];
  assign link.cnt_wr = wr_fire && paddr == twm_pkg::ADDR_WD_COUNT;
  assign link.svc_wr = wr_fire && paddr == twm_pkg::ADDR_WD_MATCH;
  assign link.wdata = pwdata[7:0];

  tick_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .slow_clock(slow_clock),
    .lk(link.presc)
  );

  watchdog_core u_watchdog (
    .pclk(pclk),
    .presetn(presetn),
    .lk(link.wdog)
  );

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign timer_tick_output = st_reg.tick;
  assign periodic_tick_irq = st_reg.irq;
  assign watchdog_reset = st_reg.wd_reset;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_count_down;
    link.prescaled_tick_clock_rise && !st_reg.restart && st_reg.cnt != 16'h0000
      |=> st_reg.cnt == $past(st_reg.cnt) - 16'h0001;
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("timer did not decrement on tick");

  property p_reload;
    link.prescaled_tick_clock_rise && st_reg.cnt == 16'h0000 |=> st_reg.cnt == $past(st_reg.preset);
  endproperty
  a_reload: assert property (p_reload)
    else $error("timer did not reload at zero");

  property p_restart;
    link.prescaled_tick_clock_rise && st_reg.restart && !wr_fire
      |=> st_reg.cnt == $past(st_reg.preset) && !st_reg.restart;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not reload and clear");

  property p_frozen;
    !link.prescaled_tick_clock_rise |=> $stable(st_reg.cnt) && $stable(st_reg.tick);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("timer moved without a prescaled tick");

  property p_flag_set;
    link.prescaled_tick_clock_rise && zero_after |=> st_reg.tc && st_reg.tick;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("terminal flag missing at zero");

  property p_irq_gate;
    periodic_tick_irq |-> st_reg.tick && $past(st_reg.inte);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("tick interrupt without enable");

  property p_cfg_sticky;
    ((~$past(st_reg.cfg)) | st_reg.cfg) == 6'h3f;
  endproperty
  a_cfg_sticky: assert property (p_cfg_sticky)
    else $error("configuration bit was cleared");

  property p_error_resets;
    link.wd_error |=> watchdog_reset;
  endproperty
  a_error_resets: assert property (p_error_resets)
    else $error("watchdog error did not request reset");

  property p_locked_read;
    access && !pwrite && mapped && !allowed |=> prdata == 32'hdead_beef;
  endproperty
  a_locked_read: assert property (p_locked_read)
    else $error("blocked register returned its contents");
endmodule : tick_timer_and_watchdog

// ### tb/tb.sv
// Self-checking bench for the tick timer and watchdog block over APB.
// Assumes the design's own assertions are active; drives slow_clock itself.
`timescale 1ns/1ns
module tb;
  localparam logic [7:0] a_cfg = twm_pkg::ADDR_CONFIG;
  localparam logic [7:0] a_psc = twm_pkg::ADDR_PRESCALER;
  localparam logic [7:0] a_pre = twm_pkg::ADDR_PRESET;
  localparam logic [7:0] a_ctl = twm_pkg::ADDR_CONTROL;
  localparam logic [7:0] a_cnt = twm_pkg::ADDR_WD_COUNT;
  localparam logic [7:0] a_svc = twm_pkg::ADDR_WD_MATCH;
  localparam logic [7:0] a_sts = twm_pkg::ADDR_STATUS;
  localparam logic [31:0] blk = twm_pkg::BLOCKED_READ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] sc_cnt = 4'h0;
  wire slow_clock = sc_cnt[3];
  twm_pkg::power_mode_t power_mode = twm_pkg::MODE_ACTIVE;
  logic tick;
  logic irq;
  logic wd_rst;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int gap;
  int t0;
  logic [31:0] rdv;
  logic err;

  always #4 pclk = ~pclk;
  // Slow clock of 16 pclk periods keeps timer runs short
  always @(posedge pclk) begin
    sc_cnt <= sc_cnt + 4'h1;
    cyc <= cyc + 1;
  end

  tick_timer_and_watchdog dut (
    .pclk(pclk),
    .presetn(presetn),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .slow_clock(slow_clock),
    .power_mode(power_mode),
    .timer_tick_output(tick),
    .periodic_tick_irq(irq),
    .watchdog_reset(wd_rst)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compared %0d mismatched %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic hang(input string what);
    n_fail++;
    $display("FAIL %0t no answer in %s", $time, what);
    stop_test();
  endtask : hang

  // One transfer, then an idle edge so psel is never assigned twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) hang("apb");
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp, what);
  endtask : rd

  task automatic tick_gap();
    logic prev;
    prev = tick;
    gap = 0;
    forever begin
      @(posedge pclk);
      gap++;
      if (tick === 1'b1 && prev !== 1'b1) break;
      prev = tick;
      if (gap > 20000) hang("tick");
    end
  endtask : tick_gap

  task automatic wd_wait(input int lim);
    gap = 0;
    while (wd_rst !== 1'b1 && gap < lim) begin
      @(posedge pclk);
      gap++;
    end
  endtask : wd_wait

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    rd(a_cfg, 32'h0, "cfg reset");
    rd(a_psc, 32'h0, "prescaler reset");
    rd(a_pre, 32'hffff, "preset reset");
    rd(a_ctl, 32'h0, "control reset");
    rd(a_cnt, 32'h0, "count write only");
    apb(1'b0, 8'h1c, 32'h0);
    chk(32'(err), 32'h1, "unmapped error");
    wd_wait(300);
    chk(32'(wd_rst), 32'h0, "idle watchdog");
    apb(1'b0, a_sts, 32'h0);
    chk(32'(rdv[8]), 32'h0, "not started");
    $display("reset test done");
    wr(a_pre, 32'h3);
    wr(a_ctl, 32'h1);
    for (int m = 0; m < 3; m++) begin
      wr(a_psc, 32'(m));
      tick_gap();
      tick_gap();
      chk(32'(gap), 32'(64 << m), "period");
    end
    wr(a_psc, 32'h0);
    tick_gap();
    chk(32'(irq), 32'h0, "irq masked");
    gap = 0;
    while (tick === 1'b1 && gap < 100) begin
      @(posedge pclk);
      gap++;
    end
    chk(32'(gap), 32'd16, "tick width");
    rd(a_ctl, 32'h2, "terminal set");
    rd(a_ctl, 32'h0, "terminal cleared");
    wr(a_ctl, 32'h6);
    rd(a_ctl, 32'h4, "terminal read only");
    tick_gap();
    @(posedge pclk);
    chk(32'(irq), 32'h1, "irq raised");
    $display("timer test done");
    tick_gap();
    t0 = cyc;
    repeat (20) @(posedge pclk);
    wr(a_pre, 32'h7);
    tick_gap();
    chk(32'(cyc - t0), 32'd64, "count in progress kept");
    tick_gap();
    chk(32'(gap), 32'd128, "new preset at reload");
    t0 = cyc;
    repeat (20) @(posedge pclk);
    wr(a_ctl, 32'h5);
    tick_gap();
    chk(32'(cyc - t0), 32'd144, "restart reload");
    rd(a_ctl, 32'h6, "restart self clears");
    $display("preset test done");
    power_mode <= twm_pkg::MODE_POWER_SAVE;
    @(posedge pclk);
    rd(a_pre, blk, "save mode blocked");
    tick_gap();
    tick_gap();
    chk(32'(gap), 32'd128, "save mode runs");
    power_mode <= twm_pkg::MODE_ACTIVE;
    tick_gap();
    t0 = cyc;
    repeat (30) @(posedge pclk);
    power_mode <= twm_pkg::MODE_HALT;
    repeat (96) @(posedge pclk);
    power_mode <= twm_pkg::MODE_ACTIVE;
    tick_gap();
    // Prescaler phase against the slow pin may shift by one slow period
    chk(32'(cyc - t0 >= 208 && cyc - t0 <= 240), 32'h1, "halt resume");
    $display("power test done");
    wr(a_cfg, 32'h10);
    wr(a_cfg, 32'h0);
    rd(a_cfg, 32'h10, "set only");
    wr(a_cfg, 32'h14);
    wr(a_pre, 32'h3);
    rd(a_pre, blk, "locked preset");
    tick_gap();
    tick_gap();
    chk(32'(gap), 32'd128, "locked write ignored");
    wr(a_cfg, 32'h15);
    rd(a_cfg, blk, "locked config");
    rd(a_psc, 32'h0, "prescaler open");
    $display("lock test done");
    do_reset();
    wr(a_cfg, 32'h10);
    wr(a_cnt, 32'h6);
    apb(1'b0, a_sts, 32'h0);
    chk(32'(rdv[8]), 32'h1, "count write starts");
    repeat (4) begin
      repeat (48) @(posedge pclk);
      wr(a_cnt, 32'h6);
    end
    wd_wait(60);
    chk(32'(wd_rst), 32'h0, "count service");
    wd_wait(50);
    chk(32'(wd_rst), 32'h1, "late service");
    do_reset();
    wr(a_pre, 32'h3);
    wr(a_ctl, 32'h1);
    wr(a_cnt, 32'h3);
    wd_wait(120);
    chk(32'(wd_rst), 32'h0, "timer tick clock slow");
    wd_wait(100);
    chk(32'(wd_rst), 32'h1, "timer tick clock");
    $display("count service test done");
    do_reset();
    wr(a_svc, 32'h33);
    apb(1'b0, a_sts, 32'h0);
    chk(32'(rdv[8]), 32'h1, "match write starts");
    wd_wait(40);
    chk(32'(wd_rst), 32'h0, "match off ignored");
    wr(a_cfg, 32'h30);
    wr(a_cnt, 32'h6);
    repeat (5) begin
      repeat (48) @(posedge pclk);
      wr(a_svc, 32'h5c);
    end
    chk(32'(wd_rst), 32'h0, "key service");
    // Three writes so two surely fall in one watchdog clock period
    repeat (3) wr(a_svc, 32'h5c);
    wd_wait(30);
    chk(32'(wd_rst), 32'h1, "early service");
    do_reset();
    wr(a_cfg, 32'h30);
    wr(a_svc, 32'h33);
    wd_wait(30);
    chk(32'(wd_rst), 32'h1, "wrong key");
    $display("match service test done");
    stop_test();
  end
endmodule : tb
